// >>> hdl/jmac_pkg.sv
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - no jog start unless the axis holds valid machine parameters
// - no jog start while another operating mode is active
// - drive enable set before requesting; no start while it is clear
// - start only on a valid direction key; positive up, negative down
// - motion only while the key is held; release ends the traverse
// - a stop request ends an active traverse normally
// - synchronized linear axis ends when position reaches working limit
// - opposite direction accepted only after the traverse has ended
// - drive enable loss aborts without the normal approach sequence
// - linear axis aborts when position crosses a traverse range limit
// - rapid or creep speed, chosen by the caller at start
// - unsynchronized axis crossing traverse limit invalidates position, aborts
// - positive end target is end soft limit minus half target range
// - negative end target is start soft limit plus half target range
// - switchover and switch-off points are placed short of that target, on the approach side
`default_nettype none
package jmac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_W = 5;
    localparam int EVT_W = 3;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SOFT_LIMIT_START = 8'h04;
    localparam logic [7:0] OFS_SOFT_LIMIT_END = 8'h08;
    localparam logic [7:0] OFS_TARGET_RANGE = 8'h0c;
    localparam logic [7:0] OFS_SWITCHOVER_DIFF = 8'h10;
    localparam logic [7:0] OFS_SWITCHOFF_DIFF = 8'h14;
    localparam logic [7:0] OFS_TRAVERSE_MIN = 8'h18;
    localparam logic [7:0] OFS_TRAVERSE_MAX = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_TARGET = 8'h2c;
    // reset values
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [31:0] LIMIT_RST = 32'h00000000;
    localparam logic [31:0] TRAVERSE_MIN_RST = 32'h80000000;
    localparam logic [31:0] TRAVERSE_MAX_RST = 32'h7fffffff;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic POS_VALID_RST = 1'b1;

    typedef struct packed {
        logic revalidate;
        logic rsv;
        logic enable_eval_off;
        logic speed_rapid;
        logic linear_axis;
        logic synchronized;
        logic params_valid;
    } jmac_ctrl_s;

    typedef struct packed {
        logic enable_in;
        logic drive_enable;
        logic stop_req;
        logic dir_neg;
        logic dir_pos;
    } jmac_pins_s;

    typedef struct packed {
        logic refused;
        logic aborted;
        logic done;
    } jmac_evt_s;

    typedef enum logic [1:0] {
        JMAC_IDLE = 2'b01,
        JMAC_RUN = 2'b10
    } jmac_state_e;
endpackage : jmac_pkg
`default_nettype wire

// >>> hdl/jmac_jog_axis.sv
`timescale 1ns/10ps
`default_nettype none
module jmac_jog_axis (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic DIR_POS_KEY,
    input wire logic DIR_NEG_KEY,
    input wire logic STOP_REQ,
    input wire logic DRIVE_ENABLE,
    input wire logic ENABLE_IN,
    input wire logic OTHER_MODE_BUSY,
    input wire logic signed [31:0] ACT_POS,
    output logic DRIVE_POS,
    output logic DRIVE_NEG,
    output logic DRIVE_RAPID,
    output logic JOG_ACTIVE,
    output logic POS_VALID,
    output logic IRQ
);
    //------------------------------------------------------------
    // declarations
    //------------------------------------------------------------
    jmac_pkg::jmac_ctrl_s ctrl;
    jmac_pkg::jmac_pins_s pins, pins_prev;
    jmac_pkg::jmac_evt_s evt, sts, next_sts;
    jmac_pkg::jmac_state_e state;
    logic [2:0] irq_mask;
    logic [4:0] pin_raw, pin_meta, pin_sync;
    logic signed [31:0] soft_limit_start, soft_limit_end, trav_min, trav_max;
    logic [31:0] target_range, switchover_diff, switchoff_diff;
    logic signed [31:0] half_range, next_target, target, over_pt, off_pt;
    logic signed [31:0] next_over_pt, next_off_pt;
    logic dir_neg, rapid;
    logic start_pos_cmd, start_neg_cmd, start_cmd, start_ok, start_go;
    logic running, sync_lin, reached_over, reached_off, key_held;
    logic crossing, abort_now, end_now, next_run, next_dir_neg, next_rapid;
    logic wr_ctrl;
    jmac_pkg::jmac_ctrl_s wr_ctrl_val;

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    assign pin_raw = {ENABLE_IN, DRIVE_ENABLE, STOP_REQ, DIR_NEG_KEY, DIR_POS_KEY};

    // keys and enables are asynchronous; two stages tame metastability
    genvar gi;
    generate
        for (gi = 0; gi < jmac_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS) begin
                if (SRST) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    assign pins = jmac_pkg::jmac_pins_s'(pin_sync);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins;
        end
    end

    //------------------------------------------------------------
    // start qualification
    //------------------------------------------------------------
    // both keys pressed together is not a valid command
    assign start_pos_cmd = pins.dir_pos & ~pins_prev.dir_pos & ~pins.dir_neg;
    assign start_neg_cmd = pins.dir_neg & ~pins_prev.dir_neg & ~pins.dir_pos;
    assign start_cmd = start_pos_cmd | start_neg_cmd;
    // stop held at the key edge counts as a refused start
    assign start_ok = ctrl.params_valid
        & ~OTHER_MODE_BUSY
        & pins.drive_enable
        & (ctrl.enable_eval_off | pins.enable_in)
        & ~pins.stop_req;
    assign running = (state == jmac_pkg::JMAC_RUN);
    // edge start in idle only: a key hit while running is never re-armed
    assign start_go = ~running & start_cmd & start_ok;

    //------------------------------------------------------------
    // end-of-range target and approach points
    //------------------------------------------------------------
    // odd target ranges round the half down
    assign half_range = $signed({1'b0, target_range[31:1]});
    assign next_target = start_neg_cmd ? soft_limit_start + half_range
                                       : soft_limit_end - half_range;
    assign next_over_pt = start_neg_cmd ? next_target + $signed(switchover_diff)
                                        : next_target - $signed(switchover_diff);
    assign next_off_pt = start_neg_cmd ? next_target + $signed(switchoff_diff)
                                       : next_target - $signed(switchoff_diff);

    //------------------------------------------------------------
    // termination and abort
    //------------------------------------------------------------
    assign sync_lin = ctrl.synchronized & ctrl.linear_axis;
    assign reached_over = dir_neg ? (ACT_POS <= over_pt) : (ACT_POS >= over_pt);
    assign reached_off = dir_neg ? (ACT_POS <= off_pt) : (ACT_POS >= off_pt);
    assign key_held = dir_neg ? pins.dir_neg : pins.dir_pos;
    // signed compares; reset limits span the whole number range
    assign crossing = (ACT_POS < trav_min) | (ACT_POS > trav_max);
    // abort outranks a normal end arriving in the same cycle
    assign abort_now = running & (~pins.drive_enable
        | (crossing & ctrl.linear_axis)
        | (crossing & ~ctrl.synchronized));
    assign end_now = running & ~abort_now & (~key_held
        | pins.stop_req
        | (sync_lin & reached_off));

    assign next_run = start_go | (running & ~abort_now & ~end_now);
    assign next_dir_neg = start_go ? start_neg_cmd : dir_neg;
    assign next_rapid = start_go ? ctrl.speed_rapid : (rapid & ~(sync_lin & reached_over));

    //------------------------------------------------------------
    // traverse state
    //------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state <= jmac_pkg::JMAC_IDLE;
            dir_neg <= 1'b0;
            rapid <= 1'b0;
            target <= jmac_pkg::LIMIT_RST;
            over_pt <= jmac_pkg::LIMIT_RST;
            off_pt <= jmac_pkg::LIMIT_RST;
        end else begin
            unique case (state)
                jmac_pkg::JMAC_IDLE: begin
                    if (start_go) begin
                        state <= jmac_pkg::JMAC_RUN;
                        dir_neg <= start_neg_cmd;
                        rapid <= ctrl.speed_rapid;
                        target <= next_target;
                        over_pt <= next_over_pt;
                        off_pt <= next_off_pt;
                    end
                end
                jmac_pkg::JMAC_RUN: begin
                    rapid <= next_rapid;
                    if (abort_now | end_now) begin
                        state <= jmac_pkg::JMAC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            JOG_ACTIVE <= 1'b0;
            DRIVE_POS <= 1'b0;
            DRIVE_NEG <= 1'b0;
            DRIVE_RAPID <= 1'b0;
        end else begin
            JOG_ACTIVE <= next_run;
            DRIVE_POS <= next_run & ~next_dir_neg;
            DRIVE_NEG <= next_run & next_dir_neg;
            DRIVE_RAPID <= next_run & next_rapid;
        end
    end

    // hardware invalidation wins over a software revalidate in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            POS_VALID <= jmac_pkg::POS_VALID_RST;
        end else if (running & crossing & ~ctrl.synchronized) begin
            POS_VALID <= 1'b0;
        end else if (wr_ctrl & wr_ctrl_val.revalidate) begin
            POS_VALID <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // register bus
    //------------------------------------------------------------
    assign wr_ctrl = WR & (ADDR == jmac_pkg::OFS_CTRL);
    // field view of a control write, for the action bit
    assign wr_ctrl_val = jmac_pkg::jmac_ctrl_s'(WDATA[6:0]);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl <= jmac_pkg::jmac_ctrl_s'(jmac_pkg::CTRL_RST);
            soft_limit_start <= jmac_pkg::LIMIT_RST;
            soft_limit_end <= jmac_pkg::LIMIT_RST;
            target_range <= jmac_pkg::LIMIT_RST;
            switchover_diff <= jmac_pkg::LIMIT_RST;
            switchoff_diff <= jmac_pkg::LIMIT_RST;
            trav_min <= jmac_pkg::TRAVERSE_MIN_RST;
            trav_max <= jmac_pkg::TRAVERSE_MAX_RST;
            irq_mask <= jmac_pkg::IRQ_MASK_RST;
        end else if (WR) begin
            unique case (ADDR)
                jmac_pkg::OFS_CTRL: begin
                    // revalidate is a write-only action bit
                    ctrl <= jmac_pkg::jmac_ctrl_s'({2'b00, WDATA[4:0]});
                end
                jmac_pkg::OFS_SOFT_LIMIT_START: soft_limit_start <= WDATA;
                jmac_pkg::OFS_SOFT_LIMIT_END: soft_limit_end <= WDATA;
                jmac_pkg::OFS_TARGET_RANGE: target_range <= WDATA;
                jmac_pkg::OFS_SWITCHOVER_DIFF: switchover_diff <= WDATA;
                jmac_pkg::OFS_SWITCHOFF_DIFF: switchoff_diff <= WDATA;
                jmac_pkg::OFS_TRAVERSE_MIN: trav_min <= WDATA;
                jmac_pkg::OFS_TRAVERSE_MAX: trav_max <= WDATA;
                jmac_pkg::OFS_IRQ_MASK: irq_mask <= WDATA[2:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                jmac_pkg::OFS_CTRL: RDATA <= {27'h0, ctrl[4:0]};
                jmac_pkg::OFS_SOFT_LIMIT_START: RDATA <= soft_limit_start;
                jmac_pkg::OFS_SOFT_LIMIT_END: RDATA <= soft_limit_end;
                jmac_pkg::OFS_TARGET_RANGE: RDATA <= target_range;
                jmac_pkg::OFS_SWITCHOVER_DIFF: RDATA <= switchover_diff;
                jmac_pkg::OFS_SWITCHOFF_DIFF: RDATA <= switchoff_diff;
                jmac_pkg::OFS_TRAVERSE_MIN: RDATA <= trav_min;
                jmac_pkg::OFS_TRAVERSE_MAX: RDATA <= trav_max;
                jmac_pkg::OFS_STATUS: RDATA <= {27'h0, POS_VALID, rapid, dir_neg, state};
                jmac_pkg::OFS_IRQ_STATUS: RDATA <= {29'h0, sts};
                jmac_pkg::OFS_IRQ_MASK: RDATA <= {29'h0, irq_mask};
                jmac_pkg::OFS_TARGET: RDATA <= target;
                default: RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    assign evt.done = end_now;
    assign evt.aborted = abort_now;
    assign evt.refused = ~running & start_cmd & ~start_ok;

    always_comb begin
        next_sts = sts;
        if (WR & (ADDR == jmac_pkg::OFS_IRQ_STATUS)) begin
            next_sts = sts & ~jmac_pkg::jmac_evt_s'(WDATA[2:0]);
        end
        // a new event beats a clear in the same cycle
        next_sts = next_sts | evt;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sts <= '0;
            IRQ <= 1'b0;
        end else begin
            sts <= next_sts;
            IRQ <= |(next_sts & irq_mask);
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    sequence s_idle_cmd;
        ~running & start_cmd;
    endsequence

    sequence s_stays_idle;
        ##1 (~JOG_ACTIVE & ~running) ##1 ~running;
    endsequence

    sequence s_drive_off;
        ~JOG_ACTIVE & ~DRIVE_POS & ~DRIVE_NEG & ~DRIVE_RAPID;
    endsequence

    AST_NO_PARAMS: assert property (s_idle_cmd and (~ctrl.params_valid) |-> s_stays_idle)
        else $error("jog started without valid parameters");
    AST_OTHER_MODE: assert property (s_idle_cmd and OTHER_MODE_BUSY |=> ~JOG_ACTIVE & sts.refused)
        else $error("jog started while another mode active");
    AST_NO_DRIVE_EN: assert property (s_idle_cmd and (~pins.drive_enable) |-> s_stays_idle)
        else $error("jog started without drive enable");
    AST_DIR_POS: assert property (start_go & start_pos_cmd |=> DRIVE_POS & ~DRIVE_NEG & JOG_ACTIVE)
        else $error("positive key did not drive positive");
    AST_RELEASE: assert property (running & ~dir_neg & ~pins.dir_pos |=> ~JOG_ACTIVE & ~DRIVE_POS)
        else $error("traverse continued after key release");
    AST_STOP: assert property (running & pins.stop_req & pins.drive_enable & ~crossing
        |=> ~JOG_ACTIVE ##0 sts.done)
        else $error("stop did not end traverse normally");
    AST_WORK_LIMIT: assert property (running & ~abort_now & sync_lin & reached_off |=> ~running)
        else $error("traverse ran past working range target");
    AST_NO_REVERSE: assert property (running ##1 running |-> $stable(dir_neg) & $stable(target))
        else $error("direction changed during traverse");
    AST_EN_LOSS: assert property (running & ~pins.drive_enable |=> ~JOG_ACTIVE & sts.aborted & ~sts.done)
        else $error("drive enable loss did not abort");
    AST_TRAV_ABORT: assert property (running & ctrl.linear_axis & crossing
        |=> ~DRIVE_POS & ~DRIVE_NEG & sts.aborted)
        else $error("traverse limit crossing did not abort");
    AST_POS_INVALID: assert property (running & crossing & ~ctrl.synchronized |=> ~POS_VALID & ~JOG_ACTIVE)
        else $error("position not invalidated on crossing");
    AST_TARGET: assert property (start_go |=> target == (dir_neg
        ? $past(soft_limit_start) + $past(half_range)
        : $past(soft_limit_end) - $past(half_range)))
        else $error("end target not at soft limit and half range");
    AST_SPEED: assert property (start_go |=> DRIVE_RAPID == $past(ctrl.speed_rapid))
        else $error("speed not latched at start");
    AST_CREEP: assert property (running & sync_lin & reached_over & next_run |=> ~DRIVE_RAPID)
        else $error("rapid kept past switchover point");

    // start refusals, second keys and speed through a traverse
    AST_REFUSED: assert property (s_idle_cmd and (~start_ok) |=> ~JOG_ACTIVE & sts.refused)
        else $error("refused start left no event");
    AST_NO_ENABLE_IN: assert property (s_idle_cmd and (~ctrl.enable_eval_off & ~pins.enable_in)
        |-> s_stays_idle)
        else $error("jog started without enable input");
    AST_DIR_NEG: assert property (start_go & start_neg_cmd |=> DRIVE_NEG & ~DRIVE_POS & JOG_ACTIVE)
        else $error("negative key did not drive negative");
    AST_NEG_RELEASE: assert property (running & dir_neg & ~pins.dir_neg |=> s_drive_off)
        else $error("negative traverse continued after release");
    AST_KEY_HELD: assert property (running & key_held & ~pins.stop_req & ~abort_now
        & ~(sync_lin & reached_off) |=> JOG_ACTIVE)
        else $error("traverse ended with key held");
    AST_KEY_IGNORED: assert property (running & ~dir_neg & pins.dir_neg & ~abort_now & ~end_now
        |=> DRIVE_POS & ~DRIVE_NEG)
        else $error("second key disturbed traverse");
    AST_CREEP_KEEP: assert property (running & ~rapid |=> ~DRIVE_RAPID)
        else $error("creep traverse went back to rapid");
    AST_POS_KEPT: assert property (running & crossing & ctrl.synchronized & POS_VALID |=> POS_VALID)
        else $error("synchronized axis lost position validity");
endmodule : jmac_jog_axis
`default_nettype wire

// >>> bench/jmac_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module jmac_drive_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic drive_pos,
    input wire logic drive_neg,
    input wire logic drive_rapid,
    input wire logic load,
    input wire logic signed [31:0] load_val,
    output logic signed [31:0] act_pos
);
    // creep is slower than rapid, so the switchover shows in the position slope
    logic signed [31:0] step;
    assign step = drive_rapid ? 32'sh4 : 32'sh1;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            act_pos <= 32'sh0;
        end else if (load) begin
            act_pos <= load_val;
        end else if (drive_pos && !drive_neg) begin
            act_pos <= act_pos + step;
        end else if (drive_neg && !drive_pos) begin
            act_pos <= act_pos - step;
        end
    end
endmodule : jmac_drive_model
`default_nettype wire

// >>> bench/tb_jmac_jog_axis.sv
`timescale 1ns/10ps
`default_nettype none
module tb_jmac_jog_axis;
    logic clk_sys, srst, bus_wr, bus_rd, key_pos, key_neg, stop_req, drive_en, enable_in, other_busy, load;
    logic drv_pos, drv_neg, drv_rapid, jog_active, pos_valid, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic signed [31:0] act_pos, load_val;
    int n_mismatch = 0;
    int checks = 0;

    jmac_jog_axis i_dut (.CLK_SYS(clk_sys), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(bus_wr), .RD(bus_rd),
        .RDATA(rdata), .DIR_POS_KEY(key_pos), .DIR_NEG_KEY(key_neg), .STOP_REQ(stop_req),
        .DRIVE_ENABLE(drive_en), .ENABLE_IN(enable_in), .OTHER_MODE_BUSY(other_busy), .ACT_POS(act_pos),
        .DRIVE_POS(drv_pos), .DRIVE_NEG(drv_neg), .DRIVE_RAPID(drv_rapid), .JOG_ACTIVE(jog_active),
        .POS_VALID(pos_valid), .IRQ(irq));
    jmac_drive_model i_drive (.clk_sys(clk_sys), .srst(srst), .drive_pos(drv_pos), .drive_neg(drv_neg),
        .drive_rapid(drv_rapid), .load(load), .load_val(load_val), .act_pos(act_pos));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask : rd_chk

    task automatic wait_act(input logic e, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge clk_sys);
            #1;
            if (jog_active === e) break;
        end
        if (i == bound) begin
            n_mismatch++;
            $display("[FAIL] jog_active wait expected %b", e);
            print_verdict();
        end
    endtask : wait_act

    task automatic load_pos(input logic signed [31:0] v);
        @(posedge clk_sys);
        load <= 1'b1;
        load_val <= v;
        @(posedge clk_sys);
        load <= 1'b0;
    endtask : load_pos

    // keys low long enough that the next press is a fresh edge
    task automatic idle_pins();
        @(posedge clk_sys);
        key_pos <= 1'b0;
        key_neg <= 1'b0;
        stop_req <= 1'b0;
        drive_en <= 1'b1;
        enable_in <= 1'b1;
        other_busy <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wr(jmac_pkg::OFS_IRQ_STATUS, 32'h7);
    endtask : idle_pins

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_reset();
        rd_chk(jmac_pkg::OFS_STATUS, 32'h11, "status reset");
        rd_chk(jmac_pkg::OFS_TRAVERSE_MIN, 32'h80000000, "traverse_min reset");
        wr(jmac_pkg::OFS_STATUS, 32'hffffffff);
        rd_chk(jmac_pkg::OFS_STATUS, 32'h11, "status read-only");
        rd_chk(8'h40, 32'h0, "unmapped read");
    endtask : t_reset

    task automatic t_refuse();
        for (int k = 0; k < 5; k++) begin
            wr(jmac_pkg::OFS_CTRL, (k == 0) ? 32'h0 : 32'h1);
            @(posedge clk_sys);
            other_busy <= (k == 1);
            drive_en <= (k != 2);
            enable_in <= (k != 3);
            stop_req <= (k == 4);
            key_pos <= 1'b1;
            repeat (6) @(posedge clk_sys);
            #1;
            check("refused jog_active", {31'h0, jog_active}, 32'h0);
            rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h4, "refused event");
            idle_pins();
        end
    endtask : t_refuse

    task automatic t_basic();
        wr(jmac_pkg::OFS_CTRL, 32'h19);
        @(posedge clk_sys);
        enable_in <= 1'b0;
        key_pos <= 1'b1;
        wait_act(1'b1, 20);
        check("pos rapid drive", {29'h0, drv_pos, drv_neg, drv_rapid}, 32'h5);
        @(posedge clk_sys);
        key_neg <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check("second key ignored", {29'h0, drv_pos, drv_neg, drv_rapid}, 32'h5);
        @(posedge clk_sys);
        key_neg <= 1'b0;
        key_pos <= 1'b0;
        wait_act(1'b0, 20);
        check("released drive", {29'h0, drv_pos, drv_neg, drv_rapid}, 32'h0);
        rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h1, "release done");
        idle_pins();
        wr(jmac_pkg::OFS_CTRL, 32'h1);
        @(posedge clk_sys);
        key_neg <= 1'b1;
        wait_act(1'b1, 20);
        check("neg creep drive", {29'h0, drv_pos, drv_neg, drv_rapid}, 32'h2);
        @(posedge clk_sys);
        stop_req <= 1'b1;
        wait_act(1'b0, 20);
        rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h1, "stop done");
        idle_pins();
    endtask : t_basic

    task automatic t_abort();
        wr(jmac_pkg::OFS_IRQ_MASK, 32'h2);
        @(posedge clk_sys);
        key_pos <= 1'b1;
        wait_act(1'b1, 20);
        @(posedge clk_sys);
        drive_en <= 1'b0;
        wait_act(1'b0, 20);
        rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h2, "enable loss abort");
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(jmac_pkg::OFS_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0);
        idle_pins();
        wr(jmac_pkg::OFS_IRQ_MASK, 32'h0);
    endtask : t_abort

    task automatic t_sync();
        int i;
        load_pos(32'sd800);
        wr(jmac_pkg::OFS_SOFT_LIMIT_END, 32'd1000);
        wr(jmac_pkg::OFS_TARGET_RANGE, 32'd20);
        wr(jmac_pkg::OFS_SWITCHOVER_DIFF, 32'd100);
        wr(jmac_pkg::OFS_SWITCHOFF_DIFF, 32'd10);
        wr(jmac_pkg::OFS_CTRL, 32'hf);
        @(posedge clk_sys);
        key_pos <= 1'b1;
        wait_act(1'b1, 20);
        rd_chk(jmac_pkg::OFS_TARGET, 32'd990, "positive target");
        for (i = 0; i < 100 && act_pos < 32'sd900; i++) @(posedge clk_sys);
        if (i == 100) begin
            n_mismatch++;
            $display("[FAIL] creep approach expected 900 seen %0d", act_pos);
            print_verdict();
        end
        #1;
        check("creep past switchover", {31'h0, drv_rapid}, 32'h0);
        wait_act(1'b0, 300);
        check("end near switch-off", {31'h0, act_pos >= 32'sd980 && act_pos <= 32'sd984}, 32'h1);
        rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h1, "limit done");
        idle_pins();
        load_pos(32'sd200);
        @(posedge clk_sys);
        key_neg <= 1'b1;
        wait_act(1'b1, 20);
        rd_chk(jmac_pkg::OFS_TARGET, 32'd10, "negative target");
        idle_pins();
        wait_act(1'b0, 20);
    endtask : t_sync

    task automatic t_cross();
        wr(jmac_pkg::OFS_TRAVERSE_MAX, 32'd850);
        for (int j = 0; j < 2; j++) begin
            load_pos(32'sd800);
            wr(jmac_pkg::OFS_CTRL, (j == 0) ? 32'h1 : 32'h7);
            @(posedge clk_sys);
            key_pos <= 1'b1;
            wait_act(1'b1, 20);
            wait_act(1'b0, 200);
            check("pos_valid after crossing", {31'h0, pos_valid}, j);
            rd_chk(jmac_pkg::OFS_IRQ_STATUS, 32'h2, "crossing abort");
            idle_pins();
            wr(jmac_pkg::OFS_CTRL, 32'h41);
            repeat (2) @(posedge clk_sys);
            #1;
            check("pos_valid restored", {31'h0, pos_valid}, 32'h1);
        end
    endtask : t_cross

    initial begin
        srst = 1'b1;
        {bus_wr, bus_rd, key_pos, key_neg, stop_req, other_busy, load} = '0;
        drive_en = 1'b1;
        enable_in = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        load_val = 32'sh0;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_refuse();
        t_basic();
        t_abort();
        t_sync();
        t_cross();
        print_verdict();
    end
endmodule : tb_jmac_jog_axis
`default_nettype wire
